// ### hw/swt_consts.svh
// Address map, key bytes, field positions and timing for the supervision timer
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SWT_ADDR_KEY       8'ha6
`define SWT_ADDR_SEL       8'ha7
`define SWT_ADDR_CFG       8'ha8
`define SWT_ADDR_STAT      8'ha9

// ----------------------------------------------------------------
// Reset values, key bytes and fields
// ----------------------------------------------------------------
`define SWT_KEY_RESET      8'hff
`define SWT_KEY_FIRST      8'h1e
`define SWT_KEY_SECOND     8'he1
`define SWT_SEL_RESET      3'h0
`define SWT_CODE_W         3
`define SWT_CFG_WATCHDOG_CLOCK_DOUBLE_BIT   0
`define SWT_CFG_X2_BIT     1
`define SWT_STAT_ARMED_BIT 0
`define SWT_STAT_HOLD_BIT  1
`define SWT_STAT_PULSE_BIT 2
`define SWT_RDATA_IDLE     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWT_OSC_PERIOD_NS  40
`define SWT_PULSE_OSC      96
`define SWT_PULSE_NS       (`SWT_PULSE_OSC * `SWT_OSC_PERIOD_NS)
`define SWT_PULSE_CYC      (`SWT_PULSE_NS / `SWT_OSC_PERIOD_NS)
`define SWT_PULSE_W        7
`define SWT_MC_OSC         4'h6
`define SWT_DIV_W          4

`endif

// ### hw/swt_pkg.sv
// Types shared by the supervision timer modules
package swt_pkg;

   typedef enum logic [2:0] {
      SWT_OFF  = 3'b001,
      SWT_RUN  = 3'b010,
      SWT_HOLD = 3'b100
   } swt_state_t;

   typedef struct packed {
      logic [7:0] last;
      logic       primed;
      logic       ok;
   } swt_key_t;

   typedef struct packed {
      logic [6:0] cnt;
      logic       out;
   } swt_pulse_t;

endpackage

// ### hw/swt_key_seq.sv
// Key byte sequencer: spots the two-byte service key with nothing between
`timescale 1ns/10ps
`default_nettype none
`include "swt_consts.svh"

module swt_key_seq
   import swt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       key_wr,
   input  wire logic       other_acc,
   input  wire logic [7:0] key_data,
   output var  logic       key_ok
);

   swt_key_t r_reg;
   swt_key_t r_next;

   always_comb begin
      r_next    = r_reg;
      r_next.ok = 1'b0;
      if (key_wr) begin
         // A second byte only counts straight after the first
         r_next.ok     = r_reg.primed && (key_data == `SWT_KEY_SECOND); // R2
         r_next.last   = key_data;
         r_next.primed = (key_data == `SWT_KEY_FIRST);
      end else if (other_acc) begin
         r_next.primed = 1'b0; // R19
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '{last: `SWT_KEY_RESET, primed: 1'b0, ok: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign key_ok = r_reg.ok;

endmodule
`default_nettype wire

// ### hw/swt_rst_pulse.sv
// Reset pin pulse stretcher: fixed number of oscillator periods
`timescale 1ns/10ps
`default_nettype none
`include "swt_consts.svh"

module swt_rst_pulse
   import swt_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output var  logic pulse
);

   localparam logic [`SWT_PULSE_W-1:0] LAST_CNT =
      `SWT_PULSE_W'(`SWT_PULSE_CYC - 1);

   swt_pulse_t r_reg;
   swt_pulse_t r_next;

   always_comb begin
      r_next = r_reg;
      if (start && !r_reg.out) begin
         r_next.out = 1'b1; // R5
         r_next.cnt = LAST_CNT;
      end else if (r_reg.out) begin
         if (r_reg.cnt == '0) begin
            r_next.out = 1'b0;
         end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '{cnt: '0, out: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign pulse = r_reg.out;

endmodule
`default_nettype wire

// ### hw/swt_top.sv
// Supervision timer: key-armed watchdog with programmable time-out
//
// How it works
// R1 - After any reset the timer is off and does not count.
// R2 - Writing 1E then E1 to the key register, nothing between, arms it.
// R3 - While armed the chain advances once per machine cycle.
// R4 - No write disarms it; only reset or its own overflow does.
// R5 - Overflow drives a 96 oscillator period pulse on the reset pin.
// R6 - Duration selection writes are ignored while armed.
// R7 - Chain is a 14-bit prescaler feeding a 7-bit programmable stage.
// R8 - Code S fires after 2^(14+S)-1 machine cycles.
// R9 - Machine cycle is 6 oscillator periods, doubled when exactly one doubling bit is set.
// R10 - In power-down the chain stops and holds its value.
// R11 - Leaving power-down through hardware reset leaves the timer off.
// R12 - After wake-up by level interrupt, counting waits for the line high.
// R13 - Software services the timer before power-down and in wake routine.
// R14 - Idle keeps the timer counting; software services it periodically.
// R15 - Upper five select bits are reserved; software writes zeros there.
// R16 - Key register at A6 is write-only; bytes are consumed as keys.
// R17 - Reset clears the duration code to zero, the shortest period.
// R18 - The key pair while armed clears the chain and restarts timing.
// R19 - A broken or wrong key pair neither arms nor restarts.
// R20 - Overflow also disarms the timer and clears its chain.
`timescale 1ns/10ps
`default_nettype none
`include "swt_consts.svh"

module swt_top
   import swt_pkg::*;
#(
   parameter int PRESCALE_W = 14,
   parameter int UPPER_W    = 7
)
(
   input  wire logic       REF_CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   input  wire logic       POWER_DOWN,
   input  wire logic       WAKE_INT_N,
   output var  logic [7:0] RDATA,
   output var  logic       RST_PIN_OUT,
   output var  logic       ARMED
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      swt_state_t                  state;
      logic [`SWT_DIV_W-1:0]       mc_div;
      logic [PRESCALE_W-1:0]       presc;
      logic [UPPER_W-1:0]          upper;
      logic [`SWT_CODE_W-1:0]      code;
      logic                        watchdog_clock_double;
      logic                        x2;
      logic                        pd_seen;
      logic                        fire;
      logic                        armed;
      logic [7:0]                  rdata;
   } swt_top_t;

   swt_top_t r_reg;
   swt_top_t r_next;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic key_wr;
   logic other_acc;
   logic sel_wr;
   logic cfg_wr;
   logic key_ok;
   logic pulse;

   assign key_wr    = WR && (ADDR == `SWT_ADDR_KEY);
   // Any other bus cycle counts as an instruction between the key bytes
   // A read of the key register breaks a pending pair as well
   assign other_acc = RD || (WR && (ADDR != `SWT_ADDR_KEY));
   assign sel_wr    = WR && (ADDR == `SWT_ADDR_SEL);
   assign cfg_wr    = WR && (ADDR == `SWT_ADDR_CFG);

   // ----------------------------------------------------------------
   // Key sequencer
   // ----------------------------------------------------------------
   swt_key_seq u_key (
      .clk       (REF_CLK),
      .rst_n     (RST_N),
      .key_wr    (key_wr),
      .other_acc (other_acc),
      .key_data  (WDATA),
      .key_ok    (key_ok)
   );

   // ----------------------------------------------------------------
   // Reset pin pulse
   // ----------------------------------------------------------------
   swt_rst_pulse u_pulse (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .start (r_reg.fire),
      .pulse (pulse)
   );

   // ----------------------------------------------------------------
   // Machine cycle divider
   // ----------------------------------------------------------------
   logic                  dbl;
   logic [`SWT_DIV_W-1:0] mc_last;
   logic                  mc_tick;
   logic                  running;

   // The doubling term follows the exclusive-or of the two bits
   assign dbl     = r_reg.watchdog_clock_double ^ r_reg.x2; // R9
   assign mc_last = dbl ? `SWT_DIV_W'((`SWT_MC_OSC << 1) - 1'b1)
                        : `SWT_DIV_W'(`SWT_MC_OSC - 1'b1); // R9
   // Oscillator is halted in power-down, so the divider and chain hold
   assign running = (r_reg.state == SWT_RUN) && !POWER_DOWN; // R10 R14
   assign mc_tick = running && (r_reg.mc_div == mc_last); // R3

   // ----------------------------------------------------------------
   // Terminal count select
   // ----------------------------------------------------------------
   logic [UPPER_W-1:0] used_mask;
   logic [UPPER_W-1:0] upper_done;
   logic               terminal;

   // Stage bit i takes part in the compare only when i is below S
   generate
      for (genvar i = 0; i < UPPER_W; i++) begin : g_mask
         assign used_mask[i] = (`SWT_CODE_W'(i) < r_reg.code); // R8
         assign upper_done[i] = r_reg.upper[i] | ~used_mask[i]; // R8
      end
   endgenerate

   // All-ones over the used length means 2^(14+S)-1 cycles have passed
   assign terminal = (&r_reg.presc) &&
                     (&upper_done); // R8

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   logic is_off;
   logic is_run;
   logic is_hold;
   logic arm;
   logic cfg_open;
   logic service;
   logic overflow;
   logic wake_enter;
   logic wake_leave;

   assign is_off     = r_reg.state == SWT_OFF;
   assign is_run     = r_reg.state == SWT_RUN;
   assign is_hold    = r_reg.state == SWT_HOLD;
   assign arm        = key_ok && is_off; // R2
   // Locking the doubling bits too means no stray write can stretch a
   // running time-out
   assign cfg_open   = is_off; // R6
   assign service    = key_ok && !is_off; // R18
   // Terminal is only acted on in the run state, never while held
   assign overflow   = is_run && terminal; // R5
   // Wake-up with the level line still low parks the chain
   assign wake_enter = is_run && r_reg.pd_seen && !POWER_DOWN &&
                       !WAKE_INT_N; // R12
   assign wake_leave = is_hold && WAKE_INT_N; // R12

   // ----------------------------------------------------------------
   // Count chain steps
   // ----------------------------------------------------------------
   logic [`SWT_DIV_W-1:0] div_step;
   logic [PRESCALE_W-1:0] presc_step;
   logic [UPPER_W-1:0]    upper_step;
   logic                  presc_carry;

   // The upper stage only moves on the prescaler's carry
   assign presc_carry = mc_tick && (&r_reg.presc); // R7
   // Divider restarts on each tick, so a machine cycle is exact
   assign div_step    = mc_tick ? '0 : r_reg.mc_div + 1'b1; // R3
   assign presc_step  = r_reg.presc + PRESCALE_W'(mc_tick); // R7
   assign upper_step  = r_reg.upper + UPPER_W'(presc_carry); // R7

   // ----------------------------------------------------------------
   // Read words
   // ----------------------------------------------------------------
   logic [7:0] sel_val;
   logic [7:0] cfg_val;
   logic [7:0] stat_val;

   // Reserved upper select bits read as zero rather than left floating
   always_comb begin
      sel_val                  = `SWT_RDATA_IDLE;
      sel_val[`SWT_CODE_W-1:0] = r_reg.code; // R15
   end

   always_comb begin
      cfg_val                    = `SWT_RDATA_IDLE;
      cfg_val[`SWT_CFG_WATCHDOG_CLOCK_DOUBLE_BIT] = r_reg.watchdog_clock_double;
      cfg_val[`SWT_CFG_X2_BIT]   = r_reg.x2;
   end

   always_comb begin
      stat_val                      = `SWT_RDATA_IDLE;
      stat_val[`SWT_STAT_ARMED_BIT] = !is_off;
      stat_val[`SWT_STAT_HOLD_BIT]  = is_hold;
      stat_val[`SWT_STAT_PULSE_BIT] = pulse;
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] rd_val;

   always_comb begin
      rd_val = `SWT_RDATA_IDLE;
      unique case (ADDR)
         `SWT_ADDR_SEL: begin
            rd_val = sel_val; // R15
         end
         `SWT_ADDR_CFG: begin
            rd_val = cfg_val;
         end
         `SWT_ADDR_STAT: begin
            rd_val = stat_val;
         end
         default: begin
            // Key register is write-only and unmapped reads give zero
            rd_val = `SWT_RDATA_IDLE; // R16
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next      = r_reg;
      r_next.fire = 1'b0;
      r_next.rdata = RD ? rd_val : `SWT_RDATA_IDLE;
      r_next.pd_seen = POWER_DOWN;

      // Prescaler feeds the upper stage on its carry
      if (running) begin
         r_next.mc_div = div_step; // R3
         r_next.presc  = presc_step; // R7
         r_next.upper  = upper_step; // R7
      end

      // Duration and doubling writes only take effect while the timer is off
      if (cfg_open) begin
         if (sel_wr) begin
            r_next.code = WDATA[`SWT_CODE_W-1:0]; // R6
         end
         if (cfg_wr) begin
            r_next.watchdog_clock_double = WDATA[`SWT_CFG_WATCHDOG_CLOCK_DOUBLE_BIT]; // R6
            r_next.x2   = WDATA[`SWT_CFG_X2_BIT];
         end
      end

      unique case (r_reg.state)
         SWT_OFF: begin
            if (arm) begin
               r_next.state  = SWT_RUN; // R2
               r_next.mc_div = '0;
               r_next.presc  = '0;
               r_next.upper  = '0;
            end
         end
         SWT_RUN: begin
            if (wake_enter) begin
               // Woken by a level interrupt still held low
               r_next.state  = SWT_HOLD; // R12
               r_next.mc_div = r_reg.mc_div;
               r_next.presc  = r_reg.presc;
               r_next.upper  = r_reg.upper;
            end else if (service) begin
               r_next.mc_div = '0; // R18
               r_next.presc  = '0;
               r_next.upper  = '0;
            end
         end
         SWT_HOLD: begin
            if (service) begin
               r_next.mc_div = '0; // R18
               r_next.presc  = '0;
               r_next.upper  = '0;
            end
            if (wake_leave) begin
               r_next.state = SWT_RUN; // R12
            end
         end
      endcase

      // Overflow beats a service arriving in the same cycle
      if (overflow) begin
         r_next.fire   = 1'b1; // R5
         r_next.state  = SWT_OFF; // R20
         r_next.mc_div = '0;
         r_next.presc  = '0;
         r_next.upper  = '0;
         r_next.code   = `SWT_SEL_RESET; // R20
         r_next.watchdog_clock_double   = 1'b0;
         r_next.x2     = 1'b0;
      end

      // No write path ever leads back to the off state
      r_next.armed = r_next.state != SWT_OFF; // R4
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         r_reg.state   <= SWT_OFF; // R1 R11
         r_reg.mc_div  <= '0;
         r_reg.presc   <= '0;
         r_reg.upper   <= '0;
         r_reg.code    <= `SWT_SEL_RESET; // R17
         r_reg.watchdog_clock_double    <= 1'b0;
         r_reg.x2      <= 1'b0;
         r_reg.pd_seen <= 1'b0;
         r_reg.fire    <= 1'b0;
         r_reg.armed   <= 1'b0;
         r_reg.rdata   <= `SWT_RDATA_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The reset pin flop sits in the stretcher, one edge behind fire
   assign RDATA       = r_reg.rdata;
   assign ARMED       = r_reg.armed;
   assign RST_PIN_OUT = pulse;

endmodule
`default_nettype wire

// ### sim/swt_chk_sva.sv
// Port assertions for the supervision timer
`timescale 1ns/10ps
`default_nettype none
module swt_chk
   import swt_pkg::*;
(
   input wire logic       REF_CLK,
   input wire logic       RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic       POWER_DOWN,
   input wire logic       WAKE_INT_N,
   input wire logic [7:0] RDATA,
   input wire logic       RST_PIN_OUT,
   input wire logic       ARMED
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ----
   // Helper logic
   // ----
   logic [7:0] hi_cnt;
   wire        k1 = WR && ADDR == 8'ha6 && WDATA == 8'h1e;
   wire        k2 = WR && ADDR == 8'ha6 && WDATA == 8'he1;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         hi_cnt <= 8'h00;
      else if (RST_PIN_OUT)
         hi_cnt <= hi_cnt + 8'h01;
      else
         hi_cnt <= 8'h00;
   end
   // ----
   // Assertions
   // ----
   a_pulse_width: assert property ($fell(RST_PIN_OUT) |-> hi_cnt == 8'h60)
      else $error("reset pulse length wrong");
   a_pulse_bound: assert property (hi_cnt <= 8'h60)
      else $error("reset pulse too long");
   a_pulse_cause: assert property ($rose(RST_PIN_OUT) |->
      !ARMED && $past(ARMED, 2)) else $error("pulse without overflow");
   a_key_arms: assert property (!ARMED && !RST_PIN_OUT && k1 ##1 k2
      |-> ##[1:3] ARMED) else $error("key pair did not arm");
   a_arm_cause: assert property ($rose(ARMED) |->
      $past(k2, 2) || $past(k2, 3)) else $error("armed without key");
   a_no_disarm: assert property ($fell(ARMED) |=> $rose(RST_PIN_OUT))
      else $error("disarmed without overflow");
   a_key_wo: assert property (RD && ADDR == 8'ha6 |=> RDATA == 8'h00)
      else $error("key register readable");
   a_sel_rsvd: assert property (RD && ADDR == 8'ha7 |=>
      RDATA[7:3] == 5'h00) else $error("reserved select bits set");
   a_pd_freeze: assert property (POWER_DOWN [*5] |-> !$fell(ARMED))
      else $error("overflow during power-down");
   a_wake_hold: assert property (!POWER_DOWN && !WAKE_INT_N &&
      $past(POWER_DOWN) |=> (!$fell(ARMED)) [*4])
      else $error("overflow while wake line low");
endmodule

bind swt_top swt_chk i_chk (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .POWER_DOWN(POWER_DOWN), .WAKE_INT_N(WAKE_INT_N),
   .RDATA(RDATA), .RST_PIN_OUT(RST_PIN_OUT), .ARMED(ARMED)
);
`default_nettype wire

// ### sim/swt_top_test.sv
// Self-checking bench for the supervision timer
`timescale 1ns/10ps
`default_nettype none
module swt_top_test
   import swt_pkg::*;
;
   logic       REF_CLK = 1'b0;
   logic       RST_N = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic       POWER_DOWN = 1'b0;
   logic       WAKE_INT_N = 1'b1;
   logic [7:0] RDATA;
   logic       RST_PIN_OUT;
   logic       ARMED;
   int         n_errors = 0;
   int         n_tests = 0;
   int         cyc = 0;
   int         t0 = 0;

   always #20 REF_CLK = ~REF_CLK;

   // Short prescaler keeps the longest code to 2047 machine cycles, 12282 clock cycles
   swt_top #(.PRESCALE_W(4), .UPPER_W(7)) i_swt_top (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .POWER_DOWN(POWER_DOWN), .WAKE_INT_N(WAKE_INT_N),
      .RDATA(RDATA), .RST_PIN_OUT(RST_PIN_OUT), .ARMED(ARMED)
   );

   // ----
   // Tasks
   // ----
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Counted on the falling edge so rising-edge readers never race it
   always @(negedge REF_CLK) begin
      cyc++;
      if (cyc == 40000) begin
         $display("MISMATCH run length expected 40000 seen hang");
         n_errors++;
         complete_run;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, got);
      n_tests++;
      if (got !== e) begin
         $display("MISMATCH %s expected %0h seen %0h", nm, e, got);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge REF_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, e, input string nm);
      @(posedge REF_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 chk(nm, e, RDATA);
   endtask

   // Both key bytes on adjacent cycles; arms or services
   task automatic key;
      @(posedge REF_CLK);
      WR <= 1'b1;
      ADDR <= 8'ha6;
      WDATA <= 8'h1e;
      @(posedge REF_CLK);
      WDATA <= 8'he1;
      @(posedge REF_CLK);
      WR <= 1'b0;
      t0 = cyc;
   endtask

   // Divider phase is not visible, so the time-out gets a small window
   task automatic expire(input int e, tol);
      int n;
      int w;
      n = cyc - t0;
      w = 0;
      while (RST_PIN_OUT !== 1'b1 && n < e + tol) begin
         @(posedge REF_CLK);
         #1 n = cyc - t0;
      end
      chk("time-out", e, (n > e - tol && n < e + tol) ? e : n);
      while (RST_PIN_OUT === 1'b1 && w < 200) begin
         @(posedge REF_CLK);
         #1 w++;
      end
      chk("pulse width", 96, w);
      chk("armed after overflow", 0, ARMED);
   endtask

   // ----
   // Scenarios
   // ----
   initial begin
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1'b1;
      #1 chk("armed at reset", 0, ARMED);
      chk("pulse at reset", 0, RST_PIN_OUT);
      rd(8'ha7, 8'h00, "select reset");
      rd(8'ha6, 8'h00, "key read");
      rd(8'h5a, 8'h00, "unmapped read");
      wr(8'ha6, 8'h1e);
      rd(8'ha7, 8'h00, "select reset");
      wr(8'ha6, 8'he1);
      wr(8'ha6, 8'h1e);
      wr(8'ha6, 8'he2);
      repeat (6) @(posedge REF_CLK);
      #1 chk("armed by bad key", 0, ARMED);
      for (int s = 0; s < 8; s++) begin
         wr(8'ha7, 8'(s));
         rd(8'ha7, 8'(s), "select code");
         key;
         wr(8'ha7, 8'(s ^ 7));
         wr(8'ha8, 8'h01);
         rd(8'ha7, 8'(s), "select locked");
         expire((2 ** (4 + s) - 1) * 6 + 4, 10);
         rd(8'ha7, 8'h00, "select after overflow");
      end
      for (int c = 1; c < 4; c++) begin
         wr(8'ha8, 8'(c));
         rd(8'ha8, 8'(c), "cfg value");
         key;
         expire(15 * 6 * (c == 3 ? 1 : 2) + 4, 16);
      end
      wr(8'ha7, 8'h01);
      key;
      rd(8'ha9, 8'h01, "status armed");
      repeat (4) begin
         repeat (120) @(posedge REF_CLK);
         key;
         #1 chk("armed after service", 1, ARMED);
      end
      expire(31 * 6 + 4, 10);
      key;
      repeat (40) @(posedge REF_CLK);
      POWER_DOWN <= 1'b1;
      repeat (400) @(posedge REF_CLK);
      POWER_DOWN <= 1'b0;
      #1 chk("armed in power-down", 1, ARMED);
      expire(90 + 4 + 400, 10);
      key;
      repeat (40) @(posedge REF_CLK);
      POWER_DOWN <= 1'b1;
      WAKE_INT_N <= 1'b0;
      repeat (100) @(posedge REF_CLK);
      POWER_DOWN <= 1'b0;
      repeat (300) @(posedge REF_CLK);
      #1 chk("armed in wake hold", 1, ARMED);
      rd(8'ha9, 8'h03, "status hold");
      @(posedge REF_CLK);
      WAKE_INT_N <= 1'b1;
      expire(90 + 4 + 403, 10);
      wr(8'ha7, 8'h05);
      key;
      repeat (20) @(posedge REF_CLK);
      RST_N <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1'b1;
      #1 chk("armed after reset", 0, ARMED);
      rd(8'ha7, 8'h00, "select after reset");
      complete_run;
   end
endmodule
`default_nettype wire
